// File: event_phase_latch.sv
// Purpose: Sticky event flag with the phases that caused it.
// Assumes: Event is a one-cycle pulse with its phases valid alongside.
// Notes: Clearing the event also forgets its phases; a new event wins.
`timescale 1ns/1ps
`include "phase_status_params.svh"

module event_phase_latch
	import phase_status_pkg::*;
(
	input  wire logic   i_clock,
	input  wire logic   i_rst,
	input  wire logic   i_event,
	input  wire phase_t i_phases,
	input  wire logic   i_clear,
	output logic        o_flag,
	output phase_t      o_phases
);

	typedef struct packed {
		logic   flag;
		phase_t phases;
	} latch_s;

	latch_s st_ff;
	latch_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (i_clear) begin
			nxt_st.flag = 1'b0;
			nxt_st.phases = `FLAGS_RESET;
		end
		if (i_event) begin
			nxt_st.flag = 1'b1;
			nxt_st.phases = nxt_st.phases | i_phases;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st_ff <= '{flag: 1'b0, phases: `FLAGS_RESET};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_flag = st_ff.flag;
	assign o_phases = st_ff.phases;

endmodule

// File: phase_event_source_status_bench.sv
// Purpose: Self-checking bench for the phase event source and no-load state registers.
// Assumes: AXI4-Lite master tasks; detector inputs driven directly by the bench.
// Notes: Ready and valid are sampled at the falling edge, where they equal their values
// at the next rising edge, so the bench never races the design's own updates.
`timescale 1ns/1ps
`include "phase_status_params.svh"

module phase_event_source_status_bench
	import phase_status_pkg::*;
;

	logic        i_clock;
	logic        i_rst;
	logic        i_awvalid;
	logic [15:0] i_awaddr;
	logic        i_wvalid;
	logic [31:0] i_wdata;
	logic [3:0]  i_wstrb;
	logic        i_bready;
	logic        i_arvalid;
	logic [15:0] i_araddr;
	logic        i_rready;
	logic        o_awready;
	logic        o_wready;
	logic        o_bvalid;
	logic [1:0]  o_bresp;
	logic        o_arready;
	logic        o_rvalid;
	logic [31:0] o_rdata;
	logic [1:0]  o_rresp;
	logic        o_irq;
	logic        ev_oc;
	logic        ev_ov;
	logic        ev_dip;
	phase_t      ph_oc;
	phase_t      ph_ov;
	phase_t      ph_dip;
	phase_t      i_total_noload_phases;
	phase_t      i_fundamental_noload_phases;
	phase_t      i_apparent_noload_phases;
	int          err_count;
	int          comparisons;
	int          src_pos [3] = '{`OC_POS, `OV_POS, `DIP_POS};
	int          ev_bit  [3] = '{`EV_OC, `EV_OV, `EV_DIP};
	logic [31:0] acc;
	logic [3:0]  wr_strb;

	phase_status_regs dut_u (
		.i_clock(i_clock), .i_rst(i_rst),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
		.i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
		.o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
		.i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
		.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.i_overcurrent_event(ev_oc), .i_overcurrent_phases(ph_oc),
		.i_overvoltage_event(ev_ov), .i_overvoltage_phases(ph_ov),
		.i_voltage_dip_event(ev_dip), .i_voltage_dip_phases(ph_dip),
		.i_total_noload_phases(i_total_noload_phases),
		.i_fundamental_noload_phases(i_fundamental_noload_phases),
		.i_apparent_noload_phases(i_apparent_noload_phases),
		.o_irq(o_irq)
	);

	always #2 i_clock = ~i_clock;

	task automatic tally_and_finish();
		if (err_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic timed_out();
		err_count++;
		tally_and_finish();
	endtask

	// Entered and left just after a rising edge; bready is left high between writes.
	task automatic wr_chk(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		logic b_ok;
		logic [1:0] r;
		b_ok = 1'b0;
		i_awvalid <= 1'b1;
		i_awaddr  <= a;
		i_wvalid  <= 1'b1;
		i_wdata   <= d;
		i_wstrb   <= wr_strb;
		i_bready  <= 1'b1;
		for (int n = 0; n < 40 && !b_ok; n++) begin
			@(negedge i_clock);
			aw_ok = i_awvalid && (o_awready === 1'b1);
			w_ok = i_wvalid && (o_wready === 1'b1);
			b_ok = (o_bvalid === 1'b1);
			r = o_bresp;
			@(posedge i_clock);
			if (aw_ok) i_awvalid <= 1'b0;
			if (w_ok) i_wvalid <= 1'b0;
		end
		if (!b_ok) timed_out();
		check({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic ar_ok;
		logic ok;
		logic [31:0] d;
		logic [1:0] r;
		ok = 1'b0;
		i_arvalid <= 1'b1;
		i_araddr  <= a;
		i_rready  <= 1'b1;
		for (int n = 0; n < 40 && !ok; n++) begin
			@(negedge i_clock);
			ar_ok = i_arvalid && (o_arready === 1'b1);
			ok = (o_rvalid === 1'b1);
			d = o_rdata;
			r = o_rresp;
			@(posedge i_clock);
			if (ar_ok) i_arvalid <= 1'b0;
		end
		if (!ok) timed_out();
		check(d, exp);
		check({30'h0, r}, {30'h0, er});
	endtask

	// One-cycle event pulse; returns at the edge that takes it, with the event lowered.
	task automatic pulse(input int k, input phase_t p);
		ev_oc  <= (k == 0);
		ev_ov  <= (k == 1);
		ev_dip <= (k == 2);
		ph_oc  <= p;
		ph_ov  <= p;
		ph_dip <= p;
		@(posedge i_clock);
		ev_oc  <= 1'b0;
		ev_ov  <= 1'b0;
		ev_dip <= 1'b0;
	endtask

	task automatic irq_exp(input logic e);
		@(negedge i_clock);
		check({31'h0, o_irq}, {31'h0, e});
		@(posedge i_clock);
	endtask

	task automatic set_nl(input int k, input phase_t p);
		i_total_noload_phases       <= (k == 0) ? p : 3'h0;
		i_fundamental_noload_phases <= (k == 1) ? p : 3'h0;
		i_apparent_noload_phases    <= (k == 2) ? p : 3'h0;
	endtask

	initial begin
		i_clock = 1'b0;
		i_rst = 1'b1;
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
		{i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
		{ev_oc, ev_ov, ev_dip, ph_oc, ph_ov, ph_dip} = '0;
		set_nl(3, 3'h0);
		err_count = 0;
		comparisons = 0;
		wr_strb = 4'hf;
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		rd_chk(`PHSRC_OFFSET, 32'h0, `RESP_OKAY);
		rd_chk(`NLSTATE_OFFSET, 32'h0, `RESP_OKAY);
		rd_chk(16'he604, 32'h0, `RESP_SLVERR);
		wr_chk(16'he610, 32'hffff_ffff, `RESP_SLVERR);
		// One event per source and phase, each read back; the source bits accumulate, masked so no irq.
		acc = 32'h0;
		for (int k = 0; k < 3; k++) begin
			for (int p = 0; p < 3; p++) begin
				pulse(k, 3'h1 << p);
				acc = acc | (32'h1 << (src_pos[k] + p));
				rd_chk(`PHSRC_OFFSET, acc, `RESP_OKAY);
			end
		end
		irq_exp(1'b0);
		rd_chk(16'he700, 32'h0007_0000, `RESP_OKAY);
		wr_chk(`PHSRC_OFFSET, 32'hffff_ffff, `RESP_OKAY);
		wr_chk(`NLSTATE_OFFSET, 32'hffff_ffff, `RESP_OKAY);
		rd_chk(`PHSRC_OFFSET, 32'h0000_7e38, `RESP_OKAY);
		rd_chk(`NLSTATE_OFFSET, 32'h0, `RESP_OKAY);
		for (int k = 0; k < 3; k++) begin
			wr_chk(16'he700, 32'h1 << ev_bit[k], `RESP_OKAY);
			acc = acc & ~(32'h7 << src_pos[k]);
			rd_chk(`PHSRC_OFFSET, acc, `RESP_OKAY);
		end
		// Enabled dip raises the interrupt two edges after the pulse; masking drops it.
		wr_chk(16'he704, 32'h1 << `EV_DIP, `RESP_OKAY);
		pulse(2, 3'h4);
		irq_exp(1'b0);
		irq_exp(1'b1);
		rd_chk(`PHSRC_OFFSET, 32'h0000_4000, `RESP_OKAY);
		wr_chk(16'he704, 32'h0, `RESP_OKAY);
		irq_exp(1'b0);
		// A clear whose byte lane is disabled must leave the flag set.
		wr_strb = 4'hb;
		wr_chk(16'he700, 32'h1 << `EV_DIP, `RESP_OKAY);
		wr_strb = 4'hf;
		rd_chk(`PHSRC_OFFSET, 32'h0000_4000, `RESP_OKAY);
		wr_chk(16'he700, 32'h1 << `EV_DIP, `RESP_OKAY);
		rd_chk(`PHSRC_OFFSET, 32'h0, `RESP_OKAY);
		// Each no-load kind, phase by phase; the main bit is cleared after every rise.
		for (int k = 0; k < 3; k++) begin
			for (int p = 0; p < 3; p++) begin
				set_nl(k, 3'h1 << p);
				@(posedge i_clock);
				@(posedge i_clock);
				rd_chk(`NLSTATE_OFFSET, 32'h1 << (3 * k + p), `RESP_OKAY);
				rd_chk(16'he700, 32'h1 << k, `RESP_OKAY);
				wr_chk(16'he700, 32'h1 << k, `RESP_OKAY);
			end
		end
		i_total_noload_phases       <= 3'h7;
		i_fundamental_noload_phases <= 3'h7;
		i_apparent_noload_phases    <= 3'h0;
		repeat (2) @(posedge i_clock);
		rd_chk(`NLSTATE_OFFSET, 32'h0000_003f, `RESP_OKAY);
		wr_chk(16'he700, 32'h7, `RESP_OKAY);
		wr_chk(16'he704, 32'h1 << `EV_APP_NL, `RESP_OKAY);
		i_apparent_noload_phases <= 3'h2;
		@(posedge i_clock);
		irq_exp(1'b0);
		irq_exp(1'b1);
		rd_chk(`NLSTATE_OFFSET, 32'h0000_00bf, `RESP_OKAY);
		wr_chk(16'he700, 32'h1 << `EV_APP_NL, `RESP_OKAY);
		irq_exp(1'b0);
		tally_and_finish();
	end

endmodule

// File: phase_status_params.svh
// Purpose: Offsets, field positions, reset values and answers of the phase status bank.
// Assumes: 32-bit register bus with byte addresses.
// Notes: Included by every module file of the bank; the package does not include it.
// Behaviour
// - Overcurrent phase A/B/C sets bits 3-5
// - Overvoltage phase A/B/C sets bits 9-11
// - Voltage dip phase A/B/C sets bits 12-14
// - Source bits 6-8 and 15 read zero
// - Bits 0-2 show total-power no-load phases
// - Total no-load phase sets main bit 0
// - Bits 3-5 show fundamental no-load phases
// - Fundamental no-load phase sets main bit 1
// - Bits 6-8 show apparent no-load phases
// - Apparent no-load phase sets main bit 2
// - No-load state bits 9-15 read zero
// - Enabled bit 16 dip raises interrupt
// - Enabled bit 2 apparent no-load raises interrupt
`ifndef PHASE_STATUS_PARAMS_SVH
`define PHASE_STATUS_PARAMS_SVH

`define PHSRC_OFFSET     16'he600
`define NLSTATE_OFFSET   16'he608
`define MAIN_STAT_OFFSET 16'he700
`define MAIN_EN_OFFSET   16'he704

`define OC_POS     3
`define OV_POS     9
`define DIP_POS    12
`define TOT_NL_POS 0
`define FUN_NL_POS 3
`define APP_NL_POS 6

`define EV_TOT_NL 0
`define EV_FUN_NL 1
`define EV_APP_NL 2
`define EV_DIP    16
`define EV_OC     17
`define EV_OV     18

`define MAIN_IMPL_MASK 32'h0007_0007
`define MAIN_EN_RESET  32'h0000_0000
`define FLAGS_RESET    3'h0

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// File: phase_status_pkg.sv
// Purpose: Types shared by the phase status bank.
// Assumes: Constants come from phase_status_params.svh.
// Notes: Bus channel states are Gray coded.
package phase_status_pkg;

	typedef enum logic [0:0] {
		WR_IDLE = 1'b0,
		WR_RESP = 1'b1
	} wr_state_e;

	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} rd_state_e;

	typedef logic [2:0] phase_t;

endpackage

// File: phase_status_regs.sv
// Purpose: Phase event source and no-load state registers with main status and interrupt.
// Assumes: Detector inputs are on i_clock; AXI4-Lite slave, one write and one read at a time.
// Notes: Main status and enable hold only the bits this bank feeds.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "phase_status_params.svh"

module phase_status_regs
	import phase_status_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [15:0] i_awaddr,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	output logic      [1:0]  o_bresp,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	input  wire logic [15:0] i_araddr,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic      [31:0] o_rdata,
	output logic      [1:0]  o_rresp,
	input  wire logic        i_overcurrent_event,
	input  wire phase_t      i_overcurrent_phases,
	input  wire logic        i_overvoltage_event,
	input  wire phase_t      i_overvoltage_phases,
	input  wire logic        i_voltage_dip_event,
	input  wire phase_t      i_voltage_dip_phases,
	input  wire phase_t      i_total_noload_phases,
	input  wire phase_t      i_fundamental_noload_phases,
	input  wire phase_t      i_apparent_noload_phases,
	output logic             o_irq
);

	typedef struct packed {
		wr_state_e   wr;
		logic        aw_got;
		logic        w_got;
		logic [15:0] awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic [1:0]  bresp;
		rd_state_e   rd;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		phase_t      tot_nl;
		phase_t      fun_nl;
		phase_t      app_nl;
		logic [31:0] enable;
		logic        irq;
	} regs_s;

	regs_s st_ff;
	regs_s nxt_st;

	logic        aw_fire;
	logic        w_fire;
	logic        ar_fire;
	logic        wr_do;
	logic [15:0] waddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic [31:0] bmask;
	logic [31:0] stat_clr;
	logic [31:0] stat_word;
	logic [15:0] src_word;
	logic [15:0] nl_word;
	phase_t      nl_rise;
	phase_t      nl_flags;
	logic        oc_flag;
	logic        ov_flag;
	logic        dip_flag;
	phase_t      oc_phases;
	phase_t      ov_phases;
	phase_t      dip_phases;

	assign o_awready = (st_ff.wr == WR_IDLE) && !st_ff.aw_got;
	assign o_wready = (st_ff.wr == WR_IDLE) && !st_ff.w_got;
	assign o_arready = (st_ff.rd == RD_IDLE);
	assign o_bvalid = (st_ff.wr == WR_RESP);
	assign o_rvalid = (st_ff.rd == RD_DATA);
	assign o_bresp = st_ff.bresp;
	assign o_rdata = st_ff.rdata;
	assign o_rresp = st_ff.rresp;
	assign o_irq = st_ff.irq;

	assign aw_fire = i_awvalid && o_awready;
	assign w_fire = i_wvalid && o_wready;
	assign ar_fire = i_arvalid && o_arready;

	// Phase source fields; the gaps stay zero.
	always_comb begin
		src_word = 16'h0000;
		src_word[`OC_POS +: 3] = oc_phases;
		src_word[`OV_POS +: 3] = ov_phases;
		src_word[`DIP_POS +: 3] = dip_phases;
	end

	// No-load state; bits 15 to 9 stay zero.
	always_comb begin
		nl_word = 16'h0000;
		nl_word[`TOT_NL_POS +: 3] = st_ff.tot_nl;
		nl_word[`FUN_NL_POS +: 3] = st_ff.fun_nl;
		nl_word[`APP_NL_POS +: 3] = st_ff.app_nl;
	end

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[`EV_TOT_NL] = nl_flags[0];
		stat_word[`EV_FUN_NL] = nl_flags[1];
		stat_word[`EV_APP_NL] = nl_flags[2];
		stat_word[`EV_DIP] = dip_flag;
		stat_word[`EV_OC] = oc_flag;
		stat_word[`EV_OV] = ov_flag;
	end

	always_comb begin
		nxt_st = st_ff;
		waddr = st_ff.aw_got ? st_ff.awaddr : i_awaddr;
		wdata = st_ff.w_got ? st_ff.wdata : i_wdata;
		wstrb = st_ff.w_got ? st_ff.wstrb : i_wstrb;
		wr_do = (st_ff.wr == WR_IDLE) && (st_ff.aw_got || aw_fire)
			&& (st_ff.w_got || w_fire);
		for (int b = 0; b < 4; b++) begin
			bmask[8*b +: 8] = {8{wstrb[b]}};
		end
		stat_clr = 32'h0000_0000;
		if (wr_do && (waddr == `MAIN_STAT_OFFSET)) begin
			stat_clr = wdata & bmask & `MAIN_IMPL_MASK;
		end
		if (aw_fire) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = i_awaddr;
		end
		if (w_fire) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = i_wdata;
			nxt_st.wstrb = i_wstrb;
		end
		unique case (st_ff.wr)
			WR_IDLE: begin
				if (wr_do) begin
					nxt_st.wr = WR_RESP;
					nxt_st.aw_got = 1'b0;
					nxt_st.w_got = 1'b0;
					nxt_st.bresp = `RESP_OKAY;
					case (waddr)
						// Status registers accept the write and keep their bits.
						`PHSRC_OFFSET, `NLSTATE_OFFSET: begin
							nxt_st.bresp = `RESP_OKAY;
						end
						`MAIN_STAT_OFFSET: begin
							nxt_st.bresp = `RESP_OKAY;
						end
						`MAIN_EN_OFFSET: begin
							nxt_st.enable = (st_ff.enable & ~bmask)
								| (wdata & bmask & `MAIN_IMPL_MASK);
						end
						default: begin
							nxt_st.bresp = `RESP_SLVERR;
						end
					endcase
				end
			end
			WR_RESP: begin
				if (i_bready) begin
					nxt_st.wr = WR_IDLE;
				end
			end
		endcase
		// Read data are a snapshot taken when the address is accepted.
		// A status bit that sets while rvalid waits shows up on the next read.
		unique case (st_ff.rd)
			RD_IDLE: begin
				if (ar_fire) begin
					nxt_st.rd = RD_DATA;
					nxt_st.rresp = `RESP_OKAY;
					case (i_araddr)
						`PHSRC_OFFSET: nxt_st.rdata = {16'h0000, src_word};
						`NLSTATE_OFFSET: nxt_st.rdata = {16'h0000, nl_word};
						`MAIN_STAT_OFFSET: nxt_st.rdata = stat_word;
						`MAIN_EN_OFFSET: nxt_st.rdata = st_ff.enable;
						default: begin
							nxt_st.rdata = 32'h0000_0000;
							nxt_st.rresp = `RESP_SLVERR;
						end
					endcase
				end
			end
			RD_DATA: begin
				if (i_rready) begin
					nxt_st.rd = RD_IDLE;
				end
			end
		endcase
		// The state follows the detectors; a phase entering no-load also latches the event.
		nxt_st.tot_nl = i_total_noload_phases;
		nxt_st.fun_nl = i_fundamental_noload_phases;
		nxt_st.app_nl = i_apparent_noload_phases;
		nl_rise[0] = |(nxt_st.tot_nl & ~st_ff.tot_nl);
		nl_rise[1] = |(nxt_st.fun_nl & ~st_ff.fun_nl);
		nl_rise[2] = |(nxt_st.app_nl & ~st_ff.app_nl);
		// Registered so the pin never glitches while status bits settle.
		nxt_st.irq = |(stat_word & st_ff.enable);
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st_ff <= '{wr: WR_IDLE, rd: RD_IDLE, enable: `MAIN_EN_RESET, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	w1c_flags u_noload_events (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_set   (nl_rise),
		.i_clear (stat_clr[`EV_APP_NL:`EV_TOT_NL]),
		.o_flags (nl_flags)
	);

	event_phase_latch u_overcurrent (
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_event  (i_overcurrent_event),
		.i_phases (i_overcurrent_phases),
		.i_clear  (stat_clr[`EV_OC]),
		.o_flag   (oc_flag),
		.o_phases (oc_phases)
	);

	event_phase_latch u_overvoltage (
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_event  (i_overvoltage_event),
		.i_phases (i_overvoltage_phases),
		.i_clear  (stat_clr[`EV_OV]),
		.o_flag   (ov_flag),
		.o_phases (ov_phases)
	);

	event_phase_latch u_voltage_dip (
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_event  (i_voltage_dip_event),
		.i_phases (i_voltage_dip_phases),
		.i_clear  (stat_clr[`EV_DIP]),
		.o_flag   (dip_flag),
		.o_phases (dip_phases)
	);

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	oc_source_a: assert property (
		i_overcurrent_event |=> stat_word[`EV_OC]
			&& ((oc_phases & $past(i_overcurrent_phases)) == $past(i_overcurrent_phases)))
		else $error("Overcurrent phases not latched with the event.");

	ov_source_a: assert property (
		i_overvoltage_event |=> stat_word[`EV_OV]
			&& ((ov_phases & $past(i_overvoltage_phases)) == $past(i_overvoltage_phases)))
		else $error("Overvoltage phases not latched with the event.");

	dip_source_a: assert property (
		i_voltage_dip_event |=> stat_word[`EV_DIP]
			&& ((dip_phases & $past(i_voltage_dip_phases)) == $past(i_voltage_dip_phases)))
		else $error("Voltage dip phases not latched with the event.");

	src_gaps_a: assert property (
		(o_rvalid && $past(ar_fire) && ($past(i_araddr) == `PHSRC_OFFSET))
			|-> (o_rdata[8:6] == 3'h0) && !o_rdata[15] && !o_rdata[2])
		else $error("Unused phase source bits read nonzero.");

	total_nl_a: assert property (
		##1 (st_ff.tot_nl == $past(i_total_noload_phases)))
		else $error("Total no-load state does not follow the detector.");

	total_evt_a: assert property (
		(|(i_total_noload_phases & ~st_ff.tot_nl)) |=> stat_word[`EV_TOT_NL])
		else $error("Total no-load event not set with its phase.");

	fund_nl_a: assert property (
		##1 (st_ff.fun_nl == $past(i_fundamental_noload_phases)))
		else $error("Fundamental no-load state does not follow the detector.");

	fund_evt_a: assert property (
		(|(i_fundamental_noload_phases & ~st_ff.fun_nl)) |=> stat_word[`EV_FUN_NL])
		else $error("Fundamental no-load event not set with its phase.");

	app_nl_a: assert property (
		##1 (st_ff.app_nl == $past(i_apparent_noload_phases)))
		else $error("Apparent no-load state does not follow the detector.");

	app_evt_a: assert property (
		(|(i_apparent_noload_phases & ~st_ff.app_nl)) |=> stat_word[`EV_APP_NL])
		else $error("Apparent no-load event not set with its phase.");

	nl_gaps_a: assert property (
		(o_rvalid && $past(ar_fire) && ($past(i_araddr) == `NLSTATE_OFFSET))
			|-> (o_rdata[15:9] == 7'h00))
		else $error("Unused no-load bits read nonzero.");

	dip_irq_a: assert property (
		(stat_word[`EV_DIP] && st_ff.enable[`EV_DIP]) |=> o_irq)
		else $error("Enabled voltage dip did not raise the interrupt.");

	app_irq_a: assert property (
		(|(i_apparent_noload_phases & ~st_ff.app_nl)) && st_ff.enable[`EV_APP_NL]
			|=> ##1 o_irq)
		else $error("Enabled apparent no-load did not raise the interrupt.");

	ro_write_a: assert property (
		wr_do && ((waddr == `PHSRC_OFFSET) || (waddr == `NLSTATE_OFFSET))
			&& !i_overcurrent_event && !i_overvoltage_event && !i_voltage_dip_event
			&& (nl_rise == 3'h0)
			|=> $stable(src_word) && $stable(stat_word))
		else $error("Write to a status register changed it.");

	irq_off_a: assert property (
		!(|(stat_word & st_ff.enable)) |=> !o_irq)
		else $error("Interrupt high with no enabled status bit.");

	// A clear with no new event must drop the flag and its phases together.
	oc_clear_a: assert property (
		stat_clr[`EV_OC] && !i_overcurrent_event
			|=> !oc_flag && (oc_phases == 3'h0))
		else $error("Overcurrent flag or phases survived a clear.");

	nl_clear_a: assert property (
		stat_clr[`EV_TOT_NL] && !nl_rise[0] |=> !stat_word[`EV_TOT_NL])
		else $error("Total no-load event survived a clear.");

	oc_event_c: cover property (i_overcurrent_event ##[1:200] stat_clr[`EV_OC]);
	nl_rise_c: cover property (nl_rise[2] ##2 o_irq[*2]);
	src_read_c: cover property (ar_fire && (i_araddr == `PHSRC_OFFSET) ##1 o_rvalid);
	unmapped_c: cover property (o_bvalid && (o_bresp == `RESP_SLVERR));

endmodule

// File: w1c_flags.sv
// Purpose: Bank of sticky flags cleared by writing a one.
// Assumes: Set and clear come from logic on the same clock.
// Notes: A set in the cycle of a clear wins.
`timescale 1ns/1ps
`include "phase_status_params.svh"

module w1c_flags
	import phase_status_pkg::*;
(
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	input  wire logic [2:0]   i_set,
	input  wire logic [2:0]   i_clear,
	output logic      [2:0]   o_flags
);

	typedef struct packed {
		logic [2:0] flags;
	} flags_s;

	flags_s st_ff;
	flags_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.flags = (st_ff.flags & ~i_clear) | i_set;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st_ff <= '{flags: `FLAGS_RESET};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_flags = st_ff.flags;

endmodule
